/* File: hdl/flow_ctl_pkg.sv */
/*
 * Constants for the program-thread and wait-condition sequencer.
 * Assumes a 125 MHz core clock and 16-bit command words.
 */
package flow_ctl_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [15:0] CMD_RESTART = 16'h00FF;
  localparam logic [15:0] CMD_FORCE_T1 = 16'h004B;
  localparam logic [15:0] CMD_T2_START = 16'h004C;
  localparam logic [15:0] CMD_WAIT_EDGE = 16'h00CC;
  localparam logic [15:0] CMD_WAIT_LEVEL = 16'h00C2;
  localparam logic [15:0] CMD_END = 16'h0000;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 120;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // ****************************************
  // Field positions and sizes
  // ****************************************
  localparam int STAT2_T2_BIT = 11;
  localparam int COND_MAX = 116;
  localparam logic [15:0] BUF_EXTRA = 16'h0001;
endpackage : flow_ctl_pkg

/* File: hdl/program_thread_and_wait_control.sv */
/*
 * Program-flow sequencer: restart, thread-one force load, thread-two start or
 * kill with buffer carving, and wait-on-edge / wait-on-level on conditions.
 * Assumes commands are presented as a decoded code plus two parameter words
 * with a valid/ready handshake, and that conditions are synchronous to clk_i.
 */
// Overview of operation
// R1: Restart command code 255 triggers a full controller restart pulse.
// R2: Immediate restart sends no acknowledge.
// R3: After restart, execution resumes as after power-on.
// R4: Force-load code 75 from thread two makes thread one load-and-run an address.
// R5: Force-load leaves thread one motion running.
// R6: Force-load sets thread one multitasking, then issues load-and-run; here both are set in the same cycle.
// R7: Thread-two start code 76 loads program into buffer carved from thread one top.
// R8: Start while thread two runs replaces its program, possibly new size.
// R9: Size zero kills thread two and ignores the address.
// R10: Thread two gets size plus one; thread one shrinks by that plus one.
// R11: When thread one stops, thread two space returns to thread one.
// R12: Program end in thread two terminates thread two.
// R13: With thread two active threads alternate, each every 240 us.
// R14: Status word two bit 11 is set while thread two is active.
// R15: Thread-two start is accepted only from thread one.
// R16: Issuer requests thread-two size 1 to 511, at most half thread one buffer.
// R17: Wait-on-edge code 204 stalls until a transition, checked each 120 us tick.
// R18: Edge state 0 waits falling, 1 waits rising; steady level never satisfies.
// R19: Neither wait has a timeout.
// R20: Wait-on-level code 194 stalls until condition equals requested level.
// R21: Wait-on-level passes at once if condition already holds.
`timescale 1ns/1ps
module program_thread_and_wait_control
  import flow_ctl_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [15:0] T1_BUF_WORDS = 16'h0400,
  parameter int NUM_COND = COND_MAX
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Command in.
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [15:0] cmd_code_i,
  input wire logic [15:0] cmd_param1_i,
  input wire logic [15:0] cmd_param2_i,
  input wire logic cmd_thread_two_i,
  input wire logic cmd_immediate_i,
  // Command result.
  output logic ack_o,
  output logic reject_o,
  // Conditions and thread-one state.
  input wire logic [NUM_COND:1] cond_i,
  input wire logic thread_one_running_i,
  // Actions toward the rest of the controller.
  output logic restart_o,
  output logic load_run_valid_o,
  output logic [15:0] load_run_addr_o,
  output logic t1_multitask_o,
  output logic t2_load_o,
  output logic [15:0] t2_addr_o,
  output logic [15:0] t2_alloc_o,
  output logic [15:0] t1_buf_size_o,
  output logic [15:0] second_internal_status_word_o,
  output logic thread_step_o,
  output logic step_thread_two_o,
  output logic wait_busy_o
);

  // ****************************************
  // Reset synchroniser
  // ****************************************
  logic rst_meta;
  logic rst_n;

  // Release reset through two flops; assertion stays asynchronous.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // Servo tick and thread alternation
  // ****************************************
  logic [31:0] tick_cnt;
  logic tick;
  logic t2_active;
  logic turn_two;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  // Free-running 120 us tick counter.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 32'h00000000;
    end else if (tick) begin
      tick_cnt <= 32'h00000000;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // Alternate threads per tick while thread two is active.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      turn_two <= 1'b0;
    end else if (!t2_active) begin
      turn_two <= 1'b0;
    end else if (tick) begin
      turn_two <= ~turn_two; // R13
    end
  end

  assign thread_step_o = tick;
  assign step_thread_two_o = t2_active & turn_two; // R13

  // ****************************************
  // Command decode
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } wait_state_e;

  wait_state_e state;
  logic wait_edge_mode;
  logic wait_level;
  logic [6:0] wait_sel;
  logic prev_cond;
  logic cur_cond;
  logic wait_met;
  logic take;
  logic is_wait;
  logic prev_valid;

  assign is_wait = (cmd_code_i == CMD_WAIT_EDGE) || (cmd_code_i == CMD_WAIT_LEVEL);
  assign cmd_ready_o = (state == ST_IDLE);
  assign take = cmd_valid_i & cmd_ready_o;
  assign cur_cond = (wait_sel >= 7'h01 && 32'(wait_sel) <= NUM_COND) ? cond_i[wait_sel] : 1'b0;
  assign wait_met = wait_edge_mode ? ((prev_cond != cur_cond) && (cur_cond == wait_level)) // R18
                                   : (cur_cond == wait_level); // R20 R21
  assign wait_busy_o = (state == ST_WAIT);

  // Wait engine: no timeout, only the condition ends a wait.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      wait_edge_mode <= 1'b0;
      wait_level <= 1'b0;
      wait_sel <= 7'h00;
      prev_cond <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take && is_wait) begin
            wait_edge_mode <= (cmd_code_i == CMD_WAIT_EDGE); // R17
            wait_level <= cmd_param2_i[0];
            wait_sel <= cmd_param1_i[6:0];
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tick) begin
            prev_cond <= cur_cond; // R17
            if (wait_met && (wait_edge_mode ? prev_valid : 1'b1)) begin
              state <= ST_IDLE; // R19
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The first sample of an edge wait is a reference only.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_valid <= 1'b0;
    end else if (state == ST_IDLE) begin
      prev_valid <= 1'b0;
    end else if (tick) begin
      prev_valid <= 1'b1;
    end
  end

  // ****************************************
  // Acknowledge, restart and force-load
  // ****************************************
  logic start_ok;
  assign start_ok = (cmd_code_i == CMD_T2_START) && !cmd_thread_two_i; // R15

  // One-cycle result pulses and action strobes.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      reject_o <= 1'b0;
      restart_o <= 1'b0;
      load_run_valid_o <= 1'b0;
      load_run_addr_o <= 16'h0000;
      t2_load_o <= 1'b0;
      t2_addr_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      reject_o <= 1'b0;
      restart_o <= 1'b0;
      load_run_valid_o <= 1'b0;
      t2_load_o <= 1'b0;
      if (take) begin
        unique case (cmd_code_i)
          CMD_RESTART: begin
            restart_o <= 1'b1; // R1
            ack_o <= !cmd_immediate_i; // R2
          end
          CMD_FORCE_T1: begin
            if (cmd_thread_two_i) begin
              load_run_valid_o <= 1'b1; // R4
              load_run_addr_o <= cmd_param1_i;
              ack_o <= 1'b1;
            end else begin
              reject_o <= 1'b1;
            end
          end
          CMD_T2_START: begin
            if (start_ok) begin
              t2_load_o <= (cmd_param2_i != 16'h0000); // R9
              t2_addr_o <= cmd_param1_i; // R7
              ack_o <= 1'b1;
            end else begin
              reject_o <= 1'b1;
            end
          end
          default: ack_o <= !is_wait;
        endcase
      end
    end
  end

  // Multitask mode is set in the same cycle as the load-and-run strobe; motion is never halted here.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      t1_multitask_o <= 1'b0; // R3
    end else if (take && cmd_code_i == CMD_FORCE_T1 && cmd_thread_two_i) begin
      t1_multitask_o <= 1'b1; // R6 R5
    end
  end

  // ****************************************
  // Thread-two allocation and status
  // ****************************************
  // Allocation: size plus one for thread two, one more word off thread one.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      t2_active <= 1'b0;
      t2_alloc_o <= 16'h0000;
    end else if (!thread_one_running_i) begin
      t2_active <= 1'b0; // R11
      t2_alloc_o <= 16'h0000;
    end else if (take && start_ok) begin
      if (cmd_param2_i == 16'h0000) begin
        t2_active <= 1'b0; // R9
        t2_alloc_o <= 16'h0000;
      end else begin
        t2_active <= 1'b1; // R8
        t2_alloc_o <= cmd_param2_i + BUF_EXTRA; // R10
      end
    end else if (take && cmd_code_i == CMD_END && cmd_thread_two_i) begin
      t2_active <= 1'b0; // R12
      t2_alloc_o <= 16'h0000;
    end
  end

  assign t1_buf_size_o = t2_active ? (T1_BUF_WORDS - t2_alloc_o - BUF_EXTRA) // R10
                                   : T1_BUF_WORDS;

  // Status word two: bit 11 mirrors thread-two activity.
  always_comb begin
    second_internal_status_word_o = 16'h0000;
    second_internal_status_word_o[STAT2_T2_BIT] = t2_active; // R14
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_restart_no_ack;
    @(posedge clk_i) disable iff (!rst_n)
    (take && cmd_code_i == CMD_RESTART && cmd_immediate_i) |=> restart_o && !ack_o;
  endproperty
  a_restart_no_ack: assert property (p_restart_no_ack) else $error("restart acked"); // R2

  property p_force_load;
    @(posedge clk_i) disable iff (!rst_n)
    (take && cmd_code_i == CMD_FORCE_T1 && cmd_thread_two_i)
      |=> load_run_valid_o && t1_multitask_o && load_run_addr_o == $past(cmd_param1_i);
  endproperty
  a_force_load: assert property (p_force_load) else $error("force load missing"); // R4

  property p_start_t1_only;
    @(posedge clk_i) disable iff (!rst_n)
    (take && cmd_code_i == CMD_T2_START && cmd_thread_two_i) |=> reject_o && !t2_load_o;
  endproperty
  a_start_t1_only: assert property (p_start_t1_only) else $error("start from t2"); // R15

  property p_kill;
    @(posedge clk_i) disable iff (!rst_n)
    (take && start_ok && cmd_param2_i == 16'h0000) |=> !t2_active && !t2_load_o;
  endproperty
  a_kill: assert property (p_kill) else $error("kill failed"); // R9

  property p_alloc;
    @(posedge clk_i) disable iff (!rst_n)
    (take && start_ok && thread_one_running_i && cmd_param2_i != 16'h0000)
      |=> t2_alloc_o == $past(cmd_param2_i) + 16'h0001;
  endproperty
  a_alloc: assert property (p_alloc) else $error("alloc wrong"); // R10

  property p_status;
    @(posedge clk_i) disable iff (!rst_n)
    second_internal_status_word_o[11] == t2_active;
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong"); // R14

  property p_t1_stop;
    @(posedge clk_i) disable iff (!rst_n)
    !thread_one_running_i |=> !t2_active && t1_buf_size_o == T1_BUF_WORDS;
  endproperty
  a_t1_stop: assert property (p_t1_stop) else $error("buffer not returned"); // R11

  property p_wait_tick;
    @(posedge clk_i) disable iff (!rst_n)
    (wait_busy_o && !tick) |=> wait_busy_o;
  endproperty
  a_wait_tick: assert property (p_wait_tick) else $error("wait left off tick"); // R17

endmodule : program_thread_and_wait_control

/* File: tb/cmd_host_model.sv */
/*
 * Host-side model that presents sequencer commands and gathers result strobes.
 * Assumes the sequencer takes a command at a rising edge while ready is high.
 */
`timescale 1ns/1ps
module cmd_host_model (
  // Clock and handshake.
  input wire logic clk_i,
  input wire logic ready_i,
  // Result strobes: restart, ack, reject, load-and-run, thread-two load.
  input wire logic [4:0] strobe_i,
  // Command words toward the sequencer.
  output logic valid_o,
  output logic [15:0] code_o,
  output logic [15:0] p1_o,
  output logic [15:0] p2_o,
  output logic thr2_o,
  output logic imm_o
);
  // ****************************************
  // Command issue
  // ****************************************
  // Idle lines carry inverted words so stale values are never mistaken for a command.
  initial begin
    valid_o = 1'b0;
    code_o = 16'hFFFF;
    p1_o = 16'hFFFF;
    p2_o = 16'hFFFF;
    thr2_o = 1'b0;
    imm_o = 1'b0;
  end

  // Holds one command until the taking edge, then gathers two cycles of strobes.
  task automatic send(input logic [15:0] code, input logic [15:0] p1,
      input logic [15:0] p2, input logic thr2, input logic imm, output logic [4:0] seen);
    int n;
    n = 0;
    @(negedge clk_i);
    valid_o = 1'b1;
    code_o = code;
    p1_o = p1;
    p2_o = p2;
    thr2_o = thr2;
    imm_o = imm;
    while (ready_i !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    seen = strobe_i;
    valid_o = 1'b0;
    code_o = ~code;
    p1_o = ~p1;
    p2_o = ~p2;
    @(negedge clk_i);
    seen = seen | strobe_i;
  endtask : send
endmodule : cmd_host_model

/* File: tb/program_thread_and_wait_control_tb_top.sv */
/*
 * Self-checking bench for the program-thread and wait sequencer.
 * Assumes a 20-cycle tick and a 1024-word thread-one buffer.
 */
`timescale 1ns/1ps
module program_thread_and_wait_control_tb_top;
  import flow_ctl_pkg::*;
  localparam int TK = 20;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [116:1] cond = '0;
  logic t1_run = 1'b1;
  logic ready, ack, rej, rst, ldrun, t2ld, mt, step, st2, busy, valid, thr2, imm;
  logic [15:0] code, p1, p2, ldrun_addr, t2_addr, alloc, t1buf, stat;
  logic [4:0] s;
  int err_total = 0;
  int checks = 0;

  // ****************************************
  // Clock, design and host
  // ****************************************
  // Free-running core clock.
  always #4 clk_i = ~clk_i;

  program_thread_and_wait_control #(.TICK_CYCLES(TK)) DUT (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_code_i(code),
    .cmd_param1_i(p1), .cmd_param2_i(p2), .cmd_thread_two_i(thr2), .cmd_immediate_i(imm),
    .ack_o(ack), .reject_o(rej), .cond_i(cond), .thread_one_running_i(t1_run),
    .restart_o(rst), .load_run_valid_o(ldrun), .load_run_addr_o(ldrun_addr),
    .t1_multitask_o(mt),
    .t2_load_o(t2ld), .t2_addr_o(t2_addr), .t2_alloc_o(alloc), .t1_buf_size_o(t1buf),
    .second_internal_status_word_o(stat), .thread_step_o(step),
    .step_thread_two_o(st2), .wait_busy_o(busy));

  cmd_host_model host (.clk_i(clk_i), .ready_i(ready), .strobe_i({rst, ack, rej, ldrun, t2ld}),
    .valid_o(valid), .code_o(code), .p1_o(p1), .p2_o(p2), .thr2_o(thr2), .imm_o(imm));

  // ****************************************
  // Checking and scenarios
  // ****************************************
  // Counts a comparison and reports a mismatch.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Waits at most lim cycles for the pending wait to finish.
  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask : idle

  // Start, refusals and force load from thread two.
  task automatic t_start_force();
    host.send(CMD_T2_START, 16'h07D0, 16'h00C8, 1'b0, 1'b0, s);
    chk("start strobes", s, 5'b01001);
    chk("t2 addr", t2_addr, 16'h07D0);
    chk("t2 alloc", alloc, 16'h00C9);
    chk("t1 buf", t1buf, 16'h0336);
    chk("t2 active", stat[STAT2_T2_BIT], 1'b1);
    host.send(CMD_T2_START, 16'h0100, 16'h0010, 1'b1, 1'b0, s);
    chk("start from two", s, 5'b00100);
    host.send(CMD_FORCE_T1, 16'h03E8, 16'h0000, 1'b0, 1'b0, s);
    chk("force from one", s[2], 1'b1);
    host.send(CMD_FORCE_T1, 16'h03E8, 16'h0000, 1'b1, 1'b0, s);
    chk("force strobes", s, 5'b01010);
    chk("load addr", ldrun_addr, 16'h03E8);
    chk("multitask", mt, 1'b1);
  endtask : t_start_force

  // Threads alternate on every step while thread two is active.
  task automatic t_alternate();
    logic prev;
    int k;
    k = 0;
    prev = 1'bx;
    for (int n = 0; n < 8 * TK && k < 6; n++) begin
      @(negedge clk_i);
      if (step === 1'b1) begin
        if (k > 0) chk("turn", st2, !prev);
        prev = st2;
        k++;
      end
    end
    chk("step count", k, 6);
  endtask : t_alternate

  // Replace, kill, end and thread-one stop.
  task automatic t_kill();
    host.send(CMD_T2_START, 16'h0200, 16'h01FF, 1'b0, 1'b0, s);
    chk("max alloc", alloc, 16'h0200);
    chk("max t1 buf", t1buf, 16'h01FF);
    host.send(CMD_T2_START, 16'hABCD, 16'h0000, 1'b0, 1'b0, s);
    chk("kill", stat[STAT2_T2_BIT], 1'b0);
    chk("kill buf", t1buf, 16'h0400);
    host.send(CMD_T2_START, 16'h0300, 16'h0001, 1'b0, 1'b0, s);
    chk("min t1 buf", t1buf, 16'h03FD);
    host.send(CMD_END, 16'h0000, 16'h0000, 1'b1, 1'b0, s);
    chk("end in two", stat[STAT2_T2_BIT], 1'b0);
    host.send(CMD_T2_START, 16'h0300, 16'h0004, 1'b0, 1'b0, s);
    t1_run = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("stop buf", t1buf, 16'h0400);
    t1_run = 1'b1;
  endtask : t_kill

  // Edge waits in both senses and level waits, held and already true.
  task automatic t_waits();
    for (int e = 0; e < 2; e++) begin
      cond[3 + e] = ~e[0];
      host.send(CMD_WAIT_EDGE, 16'(3 + e), 16'(e), 1'b0, 1'b0, s);
      repeat (3 * TK) @(negedge clk_i);
      chk("edge steady", busy, 1'b1);
      chk("ready in wait", ready, 1'b0);
      cond[3 + e] = e[0];
      idle(2 * TK + 4);
      chk("edge done", busy, 1'b0);
    end
    cond[7] = 1'b1;
    host.send(CMD_WAIT_LEVEL, 16'h0007, 16'h0001, 1'b0, 1'b0, s);
    idle(TK + 2);
    chk("level held", busy, 1'b0);
    cond[116] = 1'b1;
    host.send(CMD_WAIT_LEVEL, 16'h0074, 16'h0000, 1'b0, 1'b0, s);
    repeat (3 * TK) @(negedge clk_i);
    chk("level pending", busy, 1'b1);
    cond[116] = 1'b0;
    idle(TK + 2);
    chk("level met", busy, 1'b0);
  endtask : t_waits

  // Restart with and without immediate execution.
  task automatic t_restart();
    host.send(CMD_RESTART, 16'h0000, 16'h0000, 1'b0, 1'b1, s);
    chk("restart imm", s, 5'b10000);
    host.send(CMD_RESTART, 16'h0000, 16'h0000, 1'b1, 1'b0, s);
    chk("restart prog", s[4], 1'b1);
  endtask : t_restart

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("reset buf", t1buf, 16'h0400);
    t_start_force();
    t_alternate();
    t_kill();
    t_waits();
    t_restart();
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
endmodule : program_thread_and_wait_control_tb_top
